// >>> logic/ingress_ctrl_consts.vh
// register offsets, field positions and reset values for the ingress control bank
// assumes a 32-bit AXI4-Lite slave with one aligned word per register
`ifndef INGRESS_CTRL_CONSTS_VH
`define INGRESS_CTRL_CONSTS_VH
`define OFS_FRAME_CTRL 12'h000
`define OFS_AUTH_CTRL 12'h004
`define OFS_QUEUE_PTR 12'h008
`define OFS_PRIO_MAP 12'h00C
`define OFS_ACL_CTRL 12'h010
`define OFS_STATUS 12'h014
`define FC_CEIL_BIT 7
`define FC_DROP_UNTAG_BIT 4
`define FC_DROP_TAG_BIT 3
`define FC_DEF_PRIO_LSB 0
`define FC_RESET 8'h00
`define AUTH_ACL_BIT 2
`define AUTH_RESET 8'h00
`define PTR_PORT_LSB 16
`define PTR_QUEUE_LSB 0
`define PTR_MAX_PORT 3'h6
`define PRIO_MAP_RESET 32'h33221100
`define MODE_BLOCK 2'h1
`define MODE_PASS 2'h2
`define MODE_TRAP 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> logic/port_ingress_classify_ctrl.v
// per-port ingress control registers and the frame decision path they steer
// assumes a switch core presents one ingress frame header per cycle on frm_valid;
// all inputs are synchronous to aclk
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`include "ingress_ctrl_consts.vh"
module port_ingress_classify_ctrl #(
	parameter HOST_PORT = 3'h6
) (
	input wire aclk,
	input wire aresetn,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire frm_valid,
	input wire frm_tagged,
	input wire [2:0] frm_user_prio,
	input wire frm_class_hit,
	input wire [2:0] frm_class_prio,
	input wire frm_acl_hit,
	input wire frm_acl_drop,
	input wire [2:0] default_tag_prio,
	input wire acl_enable_in,
	output reg dec_valid,
	output reg dec_drop,
	output reg dec_to_host,
	output reg [2:0] dec_prio,
	output reg [2:0] dec_user_prio,
	output reg [1:0] dec_queue,
	output reg [2:0] port_index,
	output reg [1:0] queue_ptr
);
	// software-visible register state; reserved bits are not stored at all
	reg [7:0] frame_ctrl;
	reg [1:0] auth_mode;
	reg acl_flag;
	reg [31:0] prio_map;
	// saturating count of dropped frames, read back through the status word
	reg [15:0] drop_count;

	// write channel holding registers; AW and W may arrive in either order
	reg [11:0] wr_addr;
	reg [31:0] wr_data;
	reg [3:0] wr_strb;
	reg have_aw;
	reg have_w;

	// combinational frame decision, registered into the dec_* outputs
	reg [2:0] next_prio;
	reg next_drop;
	reg next_host;
	reg [2:0] next_user_prio;

	// write strobe for the register file and the frame control merge result
	wire wr_go;
	wire [31:0] fc_merged;

	// queue lookup shared by the frame path; upper nibble bits are ignored
	function [1:0] map_queue;
		input [31:0] map;
		input [2:0] prio;
		begin
			map_queue = map[{prio, 2'b00} +: 2];
		end
	endfunction

	// byte-lane merge used by the frame control and priority map registers
	function [31:0] merge;
		input [31:0] old;
		input [31:0] val;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					merge[i*8 +: 8] = val[i*8 +: 8];
			end
		end
	endfunction

	// true for the six word offsets this bank answers; everything else earns SLVERR
	function addr_mapped;
		input [11:0] addr;
		begin
			case (addr & 12'hFFC)
				`OFS_FRAME_CTRL, `OFS_AUTH_CTRL, `OFS_QUEUE_PTR, `OFS_PRIO_MAP,
				`OFS_ACL_CTRL, `OFS_STATUS: addr_mapped = 1'b1;
				default: addr_mapped = 1'b0;
			endcase
		end
	endfunction

	// address and data are latched independently so either may come first
	assign wr_go = have_aw && have_w && !s_axi_bvalid;
	// byte lanes above the first are dropped here, frame control is one byte wide
	assign fc_merged = merge({24'h000000, frame_ctrl}, wr_data, wr_strb) & 32'h0000009F;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			have_aw <= 1'b0;
			have_w <= 1'b0;
			wr_addr <= 12'h000;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wr_addr <= s_axi_awaddr;
				have_aw <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
				have_w <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			// both halves are in hand: answer once, bvalid itself blocks a repeat
			// an unmapped word still completes, only the response code differs
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
			end
			// readies come back only with the response taken, so a second write
			// cannot overwrite the held address or data before it is applied
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				have_aw <= 1'b0;
				have_w <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// register storage; reserved bits are never stored so they read zero
	always @(posedge aclk) begin
		if (!aresetn) begin
			frame_ctrl <= `FC_RESET;
			auth_mode <= 2'h0;
			acl_flag <= 1'b0;
			port_index <= 3'h0;
			queue_ptr <= 2'h0;
			prio_map <= `PRIO_MAP_RESET;
		end else if (wr_go) begin
			case (wr_addr & 12'hFFC)
				// bits six and five are reserved and are masked off in fc_merged
				`OFS_FRAME_CTRL: frame_ctrl <= fc_merged[7:0];
				`OFS_AUTH_CTRL: begin
					// mode 00 is reserved; a write of it leaves the old mode in place
					if (wr_strb[0] && wr_data[1:0] != 2'h0)
						auth_mode <= wr_data[1:0];
				end
				// an index past the last port is ignored rather than wrapped,
				// so the indirect tables never see a port that does not exist
				`OFS_QUEUE_PTR: begin
					if (wr_strb[2] && wr_data[18:16] <= `PTR_MAX_PORT)
						port_index <= wr_data[18:16];
					if (wr_strb[0])
						queue_ptr <= wr_data[1:0];
				end
				// the two reserved bits of each nibble are never stored
				`OFS_PRIO_MAP: prio_map <= merge(prio_map, wr_data, wr_strb) & 32'h33333333;
				// software half of the ACL enable; the core's own enable is ANDed in
				`OFS_ACL_CTRL: begin
					if (wr_strb[0])
						acl_flag <= wr_data[0];
				end
				default: ;
			endcase
		end
	end

	// read channel answers one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		// hold the answer until the master takes it; no new address meanwhile
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else if (s_axi_arvalid && s_axi_arready) begin
			// data is captured with the address, so a later register change
			// does not alter a read already under way
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			case (s_axi_araddr & 12'hFFC)
				`OFS_FRAME_CTRL: s_axi_rdata <= {24'h0, frame_ctrl};
				`OFS_AUTH_CTRL: s_axi_rdata <= {29'h0, acl_flag && acl_enable_in, auth_mode};
				`OFS_QUEUE_PTR: s_axi_rdata <= {13'h0, port_index, 14'h0, queue_ptr};
				`OFS_PRIO_MAP: s_axi_rdata <= prio_map;
				`OFS_ACL_CTRL: s_axi_rdata <= {31'h0, acl_flag};
				// status is read-only; writes to it complete with no effect
				`OFS_STATUS: s_axi_rdata <= {16'h0, drop_count};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			endcase
		end
	end

	// frame decision; ACL flag only takes effect when the core also enables ACL
	always @* begin
		// defaults first so every path assigns every decision value;
		// drop causes are ORed, any one of them is enough to discard
		// the frame, and a later branch never clears an earlier drop
		next_drop = 1'b0;
		next_host = 1'b0;
		next_user_prio = frm_user_prio;
		if (frame_ctrl[`FC_CEIL_BIT] && frm_user_prio > default_tag_prio)
			next_user_prio = default_tag_prio;
		if (frm_class_hit)
			next_prio = frm_class_prio;
		else
			next_prio = frame_ctrl[`FC_DEF_PRIO_LSB +: 3];
		if (frame_ctrl[`FC_DROP_UNTAG_BIT] && !frm_tagged)
			next_drop = 1'b1;
		if (frame_ctrl[`FC_DROP_TAG_BIT] && frm_tagged)
			next_drop = 1'b1;
		if (acl_flag && acl_enable_in) begin
			if (frm_acl_hit) begin
				if (frm_acl_drop)
					next_drop = 1'b1;
			end else begin
				case (auth_mode)
					`MODE_BLOCK: next_drop = 1'b1;
					`MODE_PASS: ;
					`MODE_TRAP: next_drop = 1'b1;
					default: ;
				endcase
			end
		end
		// trap sends every surviving frame to the host; a dropped frame stays
		// dropped, so host and drop are never raised together
		if (auth_mode == `MODE_TRAP && !next_drop)
			next_host = 1'b1;
	end

	// decision outputs registered; queue comes from the mapping of the final priority
	always @(posedge aclk) begin
		if (!aresetn) begin
			dec_valid <= 1'b0;
			dec_drop <= 1'b0;
			dec_to_host <= 1'b0;
			dec_prio <= 3'h0;
			dec_user_prio <= 3'h0;
			dec_queue <= 2'h0;
			drop_count <= 16'h0000;
		end else begin
			// dec_valid lasts one cycle; the other decision outputs hold
			// their last value until the next frame replaces them
			dec_valid <= frm_valid;
			if (frm_valid) begin
				dec_drop <= next_drop;
				dec_to_host <= next_host;
				dec_prio <= next_prio;
				dec_user_prio <= next_user_prio;
				dec_queue <= map_queue(prio_map, next_prio);
				// the count sticks at its top value instead of wrapping,
				// so a busy port never reads back a small number
				if (next_drop && drop_count != 16'hFFFF)
					drop_count <= drop_count + 16'h0001;
			end
		end
	end
endmodule // port_ingress_classify_ctrl

// >>> dv/ingress_ctrl_asserts.sv
// checker for the ingress control bank: bus answers and frame decisions
// assumes binding to port_ingress_classify_ctrl, seeing only its ports
module ingress_ctrl_asserts (
	input wire aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
	input wire s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
	input wire frm_valid, frm_class_hit, dec_valid, dec_drop, dec_to_host,
	input wire [2:0] frm_user_prio, frm_class_prio, default_tag_prio, dec_prio, dec_user_prio,
	input wire [2:0] port_index
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// address and data taken together at one edge
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("no bvalid");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no rvalid");
	// a second write must not slip in while the answer is pending
	a_ready_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("ready during bvalid");
	a_dec_pulse: assert property (frm_valid |=> dec_valid) else $error("no decision");
	a_prio_ceiling: assert property (dec_valid |-> dec_user_prio == $past(frm_user_prio) ||
		(dec_user_prio == $past(default_tag_prio) && $past(frm_user_prio) > $past(default_tag_prio)))
		else $error("user prio wrong");
	a_class_prio: assert property (frm_valid && frm_class_hit |=> dec_prio == $past(frm_class_prio))
		else $error("class prio lost");
	a_host_kept: assert property (dec_to_host |-> !dec_drop) else $error("host and drop");
	a_port_range: assert property (port_index <= 3'h6) else $error("port index range");
endmodule // ingress_ctrl_asserts

bind port_ingress_classify_ctrl ingress_ctrl_asserts ingress_ctrl_asserts_i (.*);

// >>> dv/tb.sv
// self-checking bench for the ingress control bank
// assumes the design answers over AXI4-Lite and decides one frame a cycle
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, frm_valid = 0, frm_tagged = 0, frm_class_hit = 0;
	logic frm_acl_hit = 0, frm_acl_drop = 0, acl_enable_in = 0, dec_drop, dec_to_host;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dec_valid;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdv;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, dec_queue, queue_ptr, rsp;
	logic [2:0] frm_user_prio = 0, frm_class_prio = 0, default_tag_prio = 3'h3;
	logic [2:0] dec_prio, dec_user_prio, port_index;
	int err_total = 0, samples_checked = 0, cyc = 0;
	// ctrl, tagged, user prio, hit, class prio, then expected drop, prio, user prio
	logic [35:0] rows [8] = '{36'h801615053, 36'h001615056, 36'h801215052, 36'h100000100,
		36'h101414044, 36'h081414100, 36'h0F0000070, 36'h050000050};

	port_ingress_classify_ctrl port_ingress_classify_ctrl_i (.*);

	always #2 aclk = ~aclk;

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h seen %h", n, e, s);
		end
	endtask

	// each channel released at the edge that takes it; sampled at negedge, settled
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic pa, pw, tb;
		pa = 1;
		pw = 1;
		tb = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!tb) begin
			@(negedge aclk);
			tb = s_axi_bvalid;
			pa = pa & !s_axi_awready;
			pw = pw & !s_axi_wready;
			@(posedge aclk);
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		s_axi_bready <= 0;
	endtask

	task rd(input logic [11:0] a);
		logic pa, tr;
		pa = 1;
		tr = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		while (!tr) begin
			@(negedge aclk);
			tr = s_axi_rvalid;
			rdv = s_axi_rdata;
			rsp = s_axi_rresp;
			pa = pa & !s_axi_arready;
			@(posedge aclk);
			s_axi_arvalid <= pa;
		end
		s_axi_rready <= 0;
	endtask

	// one header: tagged, user prio, hit, class prio, acl hit, acl drop
	task fr(input logic [9:0] v);
		@(posedge aclk);
		frm_valid <= 1;
		{frm_tagged, frm_user_prio, frm_class_hit, frm_class_prio, frm_acl_hit, frm_acl_drop} <= v;
		@(posedge aclk);
		frm_valid <= 0;
		@(negedge aclk);
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// the whole run is well under a thousand cycles
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			test_done;
		end
	end

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		rd(12'h00C);
		chk("map reset", rdv, 32'h33221100);
		rd(12'h004);
		chk("auth reset", rdv, 32'h0);
		foreach (rows[i]) begin
			wr(12'h000, {24'h0, rows[i][35:28]}); // never the host port
			fr({rows[i][24], rows[i][22:20], rows[i][16], rows[i][14:12], 2'h0});
			chk("drop", dec_drop, rows[i][8]);
			if (!rows[i][8]) begin
				chk("prio", dec_prio, rows[i][6:4]);
				chk("user prio", dec_user_prio, rows[i][2:0]);
			end
		end
		$display("rows done");
		wr(12'h000, 32'h0);
		for (int p = 0; p < 8; p++) begin
			fr({1'b1, p[2:0], 1'b1, p[2:0], 2'h0});
			chk("queue", dec_queue, p[2:1]);
		end
		wr(12'h00C, 32'hFFFFFFE4);
		chk("bresp ok", s_axi_bresp, 2'h0);
		rd(12'h00C);
		chk("map", rdv, 32'h33333320);
		fr({1'b1, 3'h1, 1'b1, 3'h1, 2'h0});
		chk("queue", dec_queue, 2'h2);
		chk("valid", dec_valid, 1'b1);
		$display("map done");
		wr(12'h010, 32'h1);
		rd(12'h010);
		chk("acl ctrl", rdv, 32'h1);
		acl_enable_in <= 1;
		for (int m = 1; m < 4; m++) begin
			wr(12'h004, 32'(m));
			rd(12'h004);
			chk("auth", rdv, 32'(m) | 32'h4);
			fr(10'h0);
			chk("miss drop", dec_drop, m != 2);
			fr(10'h2);
			chk("hit drop", dec_drop, 1'b0);
			chk("to host", dec_to_host, m == 3);
			fr(10'h3);
			chk("acl drop", dec_drop, 1'b1);
		end
		wr(12'h004, 32'h0);
		rd(12'h004);
		chk("auth kept", rdv, 32'h7);
		$display("auth done");
		wr(12'h008, 32'h00060002);
		chk("port index", port_index, 3'h6);
		chk("queue ptr", queue_ptr, 2'h2);
		wr(12'h008, 32'h00070001);
		chk("port index", port_index, 3'h6);
		chk("queue ptr", queue_ptr, 2'h1);
		rd(12'h014);
		chk("drop count", rdv, 32'h7);
		wr(12'h100, 32'h0);
		chk("bresp err", s_axi_bresp, 2'h2);
		rd(12'h100);
		chk("resp", rsp, 2'h2);
		chk("rdata", rdv, 32'h0);
		$display("pointer done");
		test_done;
	end
endmodule // tb
